// *** logic/dht_defines.svh ***
/*
  Offsets, field positions, reset values and counts of the dual half timer.
  Assumes inclusion by bare name from the files under logic/.
*/
`ifndef DHT_DEFINES_SVH
`define DHT_DEFINES_SVH
`define DHT_AW 8
`define DHT_OFF_CFG 8'h00
`define DHT_OFF_AMODE 8'h04
`define DHT_OFF_BMODE 8'h08
`define DHT_OFF_CTL 8'h0c
`define DHT_OFF_ALOAD 8'h10
`define DHT_OFF_BLOAD 8'h14
`define DHT_OFF_AMATCH 8'h18
`define DHT_OFF_BMATCH 8'h1c
`define DHT_OFF_APRE 8'h20
`define DHT_OFF_BPRE 8'h24
`define DHT_OFF_RIS 8'h28
`define DHT_OFF_IMR 8'h2c
`define DHT_OFF_ICR 8'h30
`define DHT_OFF_MIS 8'h34
`define DHT_OFF_AVAL 8'h38
`define DHT_OFF_BVAL 8'h3c
`define DHT_CTL_A_LSB 0
`define DHT_CTL_B_LSB 8
`define DHT_CTL_W 5
`define DHT_ST_W 6
`define DHT_ST_TOUT_A 0
`define DHT_ST_CAPT_A 1
`define DHT_ST_RTC 2
`define DHT_ST_TOUT_B 4
`define DHT_ST_CAPT_B 5
`define DHT_RST_CNT16 16'hffff
`define DHT_RST_CNT32 32'hffff_ffff
`define DHT_RST_PRE 8'h00
`define DHT_RTC_FIRST 32'h0000_0001
`define DHT_RTC_IN_HZ 32768
`define DHT_RTC_OUT_HZ 1
`define DHT_RTC_DIV (`DHT_RTC_IN_HZ / `DHT_RTC_OUT_HZ)
`endif

// *** logic/dht_pkg.sv ***
/*
  Types of the dual half timer: configurations, half modes, control fields.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dht_pkg;
  typedef enum logic [2:0] {
    DHT_CFG_32 = 3'b000,
    DHT_CFG_RTC = 3'b001,
    DHT_CFG_16 = 3'b100
  } dht_cfg_type;
  typedef enum logic [2:0] {
    DHT_ONESHOT = 3'b000,
    DHT_PERIODIC = 3'b001,
    DHT_EDGE_CNT = 3'b010,
    DHT_EDGE_TIME = 3'b011,
    DHT_PWM = 3'b100
  } dht_mode_type;
  typedef struct packed {
    logic inv;
    logic trig;
    logic fall;
    logic stall;
    logic en;
  } dht_ctl_type;
endpackage

// *** logic/dht_half.sv ***
/*
  One 16-bit counter half with 8-bit prescaler and its 16-bit modes.
  Assumes run_in already folds in enable, stall and configuration.
*/
`timescale 1ns/1ps
module dht_half #(
  parameter int W = 16,
  parameter int PW = 8
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic run_in,
  input wire dht_pkg::dht_mode_type mode_in,
  input wire logic fall_in,
  input wire logic pin_in,
  input wire logic reload_in,
  input wire logic [W-1:0] load_in,
  input wire logic [W-1:0] match_in,
  input wire logic [PW-1:0] pre_in,
  output logic [W-1:0] val_out,
  output logic tout_out,
  output logic capt_out,
  output logic pwm_out
);
  logic [W-1:0] cnt_r, cnt_nxt, cap_r;
  logic [PW-1:0] pre_r, pre_nxt;
  logic pin_r, pwm_r;
  wire edge_w = fall_in ? (pin_r & ~pin_in) : (~pin_r & pin_in);
  wire zero_w = (cnt_r == '0);
  wire [W-1:0] wrap_w = zero_w ? load_in : cnt_r - 1'b1;
  always_comb begin
    cnt_nxt = cnt_r;
    pre_nxt = pre_r;
    tout_out = 1'b0;
    capt_out = 1'b0;
    if (reload_in) begin
      cnt_nxt = load_in;
      pre_nxt = pre_in;
    end else if (run_in) begin
      case (mode_in)
        dht_pkg::DHT_ONESHOT, dht_pkg::DHT_PERIODIC: begin
          // Prescaler only here, never in capture or PWM modes
          if (pre_r != '0) begin
            pre_nxt = pre_r - 1'b1;
          end else begin
            pre_nxt = pre_in;
            cnt_nxt = wrap_w;
            tout_out = zero_w;
          end
        end
        dht_pkg::DHT_EDGE_CNT: begin
          if (edge_w) begin
            cnt_nxt = (cnt_r == match_in) ? load_in : cnt_r - 1'b1;
            capt_out = (cnt_r == match_in);
          end
        end
        dht_pkg::DHT_EDGE_TIME: begin
          cnt_nxt = wrap_w;
          capt_out = edge_w;
        end
        dht_pkg::DHT_PWM: begin
          cnt_nxt = wrap_w;
        end
        default: begin
        end
      endcase
    end
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_r <= {W{1'b1}};
      pre_r <= '0;
      cap_r <= '0;
      pin_r <= 1'b0;
      pwm_r <= 1'b0;
    end else if (ce_in) begin
      cnt_r <= cnt_nxt;
      pre_r <= pre_nxt;
      pin_r <= pin_in;
      pwm_r <= (cnt_r > match_in);
      if (capt_out && mode_in == dht_pkg::DHT_EDGE_TIME) begin
        cap_r <= cnt_r;
      end
    end
  end
  assign val_out = (mode_in == dht_pkg::DHT_EDGE_TIME) ? cap_r : cnt_r;
  assign pwm_out = pwm_r;
endmodule

// *** logic/dht_timer.sv ***
/*
  Dual half timer block: register file, 32-bit and RTC engine, two halves.
  Assumes a one-cycle strobe register master and pins synchronous to clk_in.
*/
`timescale 1ns/1ps
`include "dht_defines.svh"
module dht_timer #(
  parameter int RTC_DIV = `DHT_RTC_DIV
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic [`DHT_AW-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic halt_in,
  input wire logic alternate_function_bit_a_in,
  input wire logic alternate_function_bit_b_in,
  input wire logic gpio_a_out_in,
  input wire logic gpio_a_oe_in,
  input wire logic gpio_b_out_in,
  input wire logic gpio_b_oe_in,
  input wire logic ccp_a_in,
  input wire logic ccp_b_in,
  output logic ccp_a_out,
  output logic ccp_a_oe_out,
  output logic ccp_b_out,
  output logic ccp_b_oe_out,
  input wire logic adc_chain_in,
  output logic adc_trig_out
);
  localparam logic [15:0] RTC_LAST = 16'(RTC_DIV - 1);

  dht_pkg::dht_cfg_type cfg_r, cfg_nxt;
  dht_pkg::dht_mode_type amode_r, bmode_r;
  dht_pkg::dht_ctl_type ctla_r, ctla_nxt, ctlb_r, ctlb_nxt;
  logic [15:0] aload_r, bload_r, amatch_r, bmatch_r;
  logic [7:0] apre_r, bpre_r;
  logic [`DHT_ST_W-1:0] ris_r, ris_nxt, imr_r, st_set;
  logic [31:0] cnt32_r, cnt32_nxt, rdata_r;
  logic [15:0] rtcdiv_r;
  logic ldpend_a_r, ldpend_b_r, rtc_pin_r, adc_r;
  logic pa_r, pa_oe_r, pb_r, pb_oe_r;
  logic [15:0] aval, bval;
  logic tout_a, capt_a, pwm_a, tout_b, capt_b, pwm_b;

  // Address decode
  wire sel_cfg = (addr_in == `DHT_OFF_CFG);
  wire sel_amode = (addr_in == `DHT_OFF_AMODE);
  wire sel_bmode = (addr_in == `DHT_OFF_BMODE);
  wire sel_ctl = (addr_in == `DHT_OFF_CTL);
  wire sel_aload = (addr_in == `DHT_OFF_ALOAD);
  wire sel_bload = (addr_in == `DHT_OFF_BLOAD);
  wire sel_amatch = (addr_in == `DHT_OFF_AMATCH);
  wire sel_bmatch = (addr_in == `DHT_OFF_BMATCH);
  wire sel_apre = (addr_in == `DHT_OFF_APRE);
  wire sel_bpre = (addr_in == `DHT_OFF_BPRE);
  wire sel_ris = (addr_in == `DHT_OFF_RIS);
  wire sel_imr = (addr_in == `DHT_OFF_IMR);
  wire sel_icr = (addr_in == `DHT_OFF_ICR);
  wire sel_mis = (addr_in == `DHT_OFF_MIS);
  wire sel_aval = (addr_in == `DHT_OFF_AVAL);
  wire sel_bval = (addr_in == `DHT_OFF_BVAL);
  wire wr_cfg = wr_in & sel_cfg;
  wire wr_ctl = wr_in & sel_ctl;
  wire wr_aload = wr_in & sel_aload;
  wire wr_bload = wr_in & sel_bload;
  wire wr_amatch = wr_in & sel_amatch;
  wire wr_icr = wr_in & sel_icr;

  // Configuration decode
  wire is32 = (cfg_r == dht_pkg::DHT_CFG_32);
  wire isrtc = (cfg_r == dht_pkg::DHT_CFG_RTC);
  wire is16 = (cfg_r == dht_pkg::DHT_CFG_16);
  wire wide = is32 | isrtc;
  wire [31:0] load32 = {bload_r, aload_r};
  wire [31:0] match32 = {bmatch_r, amatch_r};

  // Pins reach the timer only with the alternate function selected
  wire pin_a = alternate_function_bit_a_in & ccp_a_in;
  wire pin_b = alternate_function_bit_b_in & ccp_b_in;

  // Stall freezes timing but never the RTC
  wire halt_a = ctla_r.stall & halt_in;
  wire halt_b = ctlb_r.stall & halt_in;
  wire run32 = is32 & ctla_r.en & ~halt_a;
  wire run_a = is16 & ctla_r.en & ~halt_a;
  wire run_b = is16 & ctlb_r.en & ~halt_b;
  wire tout32 = run32 & (cnt32_r == 32'h0000_0000);
  wire os_a = (amode_r == dht_pkg::DHT_ONESHOT);
  wire os_b = (bmode_r == dht_pkg::DHT_ONESHOT);

  // RTC: 32.768 kHz edges divided down to one count per second
  wire rtc_run = isrtc & ctla_r.en;
  wire rtc_edge = pin_a & ~rtc_pin_r;
  wire rtc_sec = rtc_run & rtc_edge & (rtcdiv_r == RTC_LAST);
  wire rtc_hit = rtc_sec & (cnt32_r == match32);
  wire [2:0] wcfg = wdata_in[2:0];
  wire rtc_enter = wr_cfg & (wcfg == 3'h1) & ~isrtc;

  dht_half u_half_a (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .run_in(run_a),
    .mode_in(amode_r),
    .fall_in(ctla_r.fall),
    .pin_in(pin_a),
    .reload_in(ldpend_a_r),
    .load_in(aload_r),
    .match_in(amatch_r),
    .pre_in(apre_r),
    .val_out(aval),
    .tout_out(tout_a),
    .capt_out(capt_a),
    .pwm_out(pwm_a)
  );

  dht_half u_half_b (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .run_in(run_b),
    .mode_in(bmode_r),
    .fall_in(ctlb_r.fall),
    .pin_in(pin_b),
    .reload_in(ldpend_b_r),
    .load_in(bload_r),
    .match_in(bmatch_r),
    .pre_in(bpre_r),
    .val_out(bval),
    .tout_out(tout_b),
    .capt_out(capt_b),
    .pwm_out(pwm_b)
  );

  // Combined counter
  always_comb begin
    cnt32_nxt = cnt32_r;
    if (rtc_enter) begin
      cnt32_nxt = `DHT_RTC_FIRST;
    end else if (ldpend_a_r && is32) begin
      cnt32_nxt = load32;
    end else if (run32) begin
      cnt32_nxt = tout32 ? load32 : cnt32_r - 32'h0000_0001;
    end else if (rtc_sec) begin
      cnt32_nxt = rtc_hit ? 32'h0000_0000 : cnt32_r + 32'h0000_0001;
    end
  end

  // One-shot stop; a software write in the same cycle wins
  wire stop_a = (is32 & os_a & tout32) | (is16 & os_a & tout_a);
  wire stop_b = is16 & os_b & tout_b;
  always_comb begin
    ctla_nxt = ctla_r;
    ctlb_nxt = ctlb_r;
    if (wr_ctl) begin
      ctla_nxt = dht_pkg::dht_ctl_type'(wdata_in[`DHT_CTL_A_LSB +: `DHT_CTL_W]);
      ctlb_nxt = dht_pkg::dht_ctl_type'(wdata_in[`DHT_CTL_B_LSB +: `DHT_CTL_W]);
    end else begin
      if (stop_a) begin
        ctla_nxt.en = 1'b0;
      end
      if (stop_b) begin
        ctlb_nxt.en = 1'b0;
      end
    end
  end

  // Sticky status; a set in the clearing cycle survives
  always_comb begin
    st_set = '0;
    st_set[`DHT_ST_TOUT_A] = tout32 | tout_a;
    st_set[`DHT_ST_CAPT_A] = capt_a;
    st_set[`DHT_ST_RTC] = rtc_hit;
    st_set[`DHT_ST_TOUT_B] = tout_b;
    st_set[`DHT_ST_CAPT_B] = capt_b;
    ris_nxt = ris_r;
    if (wr_icr) begin
      ris_nxt = ris_r & ~wdata_in[`DHT_ST_W-1:0];
    end
    ris_nxt = ris_nxt | st_set;
  end
  wire [`DHT_ST_W-1:0] mis_w = ris_r & imr_r;

  wire trig_w = (st_set[`DHT_ST_TOUT_A] & ctla_r.trig) | (tout_b & ctlb_r.trig);
  wire cfg_ok = (wcfg == 3'h0) | (wcfg == 3'h1) | (wcfg == 3'h4);
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_cfg && cfg_ok) begin
      cfg_nxt = dht_pkg::dht_cfg_type'(wcfg);
    end
  end

  // Read mux; unmapped offsets read zero
  wire [31:0] ctl_rd = {19'h0_0000, ctlb_r, 3'h0, ctla_r};
  wire [31:0] aval_rd = wide ? cnt32_r : {16'h0000, aval};
  wire [31:0] bval_rd = wide ? {16'h0000, cnt32_r[31:16]} : {16'h0000, bval};
  wire [31:0] rd_mux =
    sel_cfg ? {29'h0000_0000, cfg_r} :
    sel_amode ? {29'h0000_0000, amode_r} :
    sel_bmode ? {29'h0000_0000, bmode_r} :
    sel_ctl ? ctl_rd :
    sel_aload ? (wide ? load32 : {16'h0000, aload_r}) :
    sel_bload ? {16'h0000, bload_r} :
    sel_amatch ? (wide ? match32 : {16'h0000, amatch_r}) :
    sel_bmatch ? {16'h0000, bmatch_r} :
    sel_apre ? {24'h00_0000, apre_r} :
    sel_bpre ? {24'h00_0000, bpre_r} :
    sel_ris ? {26'h000_0000, ris_r} :
    sel_imr ? {26'h000_0000, imr_r} :
    sel_mis ? {26'h000_0000, mis_w} :
    sel_aval ? aval_rd :
    sel_bval ? bval_rd : 32'h0000_0000;

  // Pin drive: GPIO unless selected; timer drives only in PWM
  wire pwm_a_on = is16 & (amode_r == dht_pkg::DHT_PWM);
  wire pwm_b_on = is16 & (bmode_r == dht_pkg::DHT_PWM);
  wire pa_nxt = alternate_function_bit_a_in ? (pwm_a ^ ctla_r.inv) : gpio_a_out_in;
  wire pa_oe_nxt = alternate_function_bit_a_in ? pwm_a_on : gpio_a_oe_in;
  wire pb_nxt = alternate_function_bit_b_in ? (pwm_b ^ ctlb_r.inv) : gpio_b_out_in;
  wire pb_oe_nxt = alternate_function_bit_b_in ? pwm_b_on : gpio_b_oe_in;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_r <= dht_pkg::DHT_CFG_32;
      amode_r <= dht_pkg::DHT_ONESHOT;
      bmode_r <= dht_pkg::DHT_ONESHOT;
      ctla_r <= '0;
      ctlb_r <= '0;
      aload_r <= `DHT_RST_CNT16;
      bload_r <= `DHT_RST_CNT16;
      amatch_r <= 16'h0000;
      bmatch_r <= 16'h0000;
      apre_r <= `DHT_RST_PRE;
      bpre_r <= `DHT_RST_PRE;
      ris_r <= '0;
      imr_r <= '0;
      cnt32_r <= `DHT_RST_CNT32;
      rtcdiv_r <= 16'h0000;
      ldpend_a_r <= 1'b0;
      ldpend_b_r <= 1'b0;
      rtc_pin_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      adc_r <= 1'b0;
      pa_r <= 1'b0;
      pa_oe_r <= 1'b0;
      pb_r <= 1'b0;
      pb_oe_r <= 1'b0;
    end else if (ce_in) begin
      cfg_r <= cfg_nxt;
      ctla_r <= ctla_nxt;
      ctlb_r <= ctlb_nxt;
      ris_r <= ris_nxt;
      cnt32_r <= cnt32_nxt;
      rtc_pin_r <= pin_a;
      rdata_r <= rd_in ? rd_mux : 32'h0000_0000;
      adc_r <= trig_w | adc_chain_in;
      pa_r <= pa_nxt;
      pa_oe_r <= pa_oe_nxt;
      pb_r <= pb_nxt;
      pb_oe_r <= pb_oe_nxt;
      ldpend_a_r <= wr_aload;
      ldpend_b_r <= wr_bload | (wr_aload & wide);
      if (rtc_enter || !rtc_run) begin
        rtcdiv_r <= 16'h0000;
      end else if (rtc_edge) begin
        rtcdiv_r <= (rtcdiv_r == RTC_LAST) ? 16'h0000 : rtcdiv_r + 16'h0001;
      end
      if (wr_in && sel_amode) begin
        amode_r <= dht_pkg::dht_mode_type'(wdata_in[2:0]);
      end
      if (wr_in && sel_bmode) begin
        bmode_r <= dht_pkg::dht_mode_type'(wdata_in[2:0]);
      end
      if (wr_aload) begin
        aload_r <= wdata_in[15:0];
      end
      if (wr_bload || (wr_aload && wide)) begin
        bload_r <= wr_bload ? wdata_in[15:0] : wdata_in[31:16];
      end
      if (wr_amatch) begin
        amatch_r <= wdata_in[15:0];
      end
      if ((wr_in && sel_bmatch) || (wr_amatch && wide)) begin
        bmatch_r <= wr_amatch ? wdata_in[31:16] : wdata_in[15:0];
      end
      if (wr_in && sel_apre) begin
        apre_r <= wdata_in[7:0];
      end
      if (wr_in && sel_bpre) begin
        bpre_r <= wdata_in[7:0];
      end
      if (wr_in && sel_imr) begin
        imr_r <= wdata_in[`DHT_ST_W-1:0];
      end
    end
  end

  assign rdata_out = rdata_r;
  assign adc_trig_out = adc_r;
  assign ccp_a_out = pa_r;
  assign ccp_a_oe_out = pa_oe_r;
  assign ccp_b_out = pb_r;
  assign ccp_b_oe_out = pb_oe_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  a_ris_sticky_hold: assert property (
    ce_in && ris_r[`DHT_ST_TOUT_A] && !wr_icr |=> ris_r[`DHT_ST_TOUT_A])
    else $error("raw time-out flag dropped without clear");
  a_mis_needs_mask: assert property (
    ce_in && tout32 && imr_r[`DHT_ST_TOUT_A] && !(wr_in && sel_imr)
    |=> mis_w[`DHT_ST_TOUT_A])
    else $error("masked time-out missing");
  a_oneshot_stops: assert property (
    ce_in && is32 && os_a && tout32 && !wr_ctl |=> !ctla_r.en)
    else $error("one-shot did not clear enable");
  a_wrap_reload: assert property (
    ce_in && tout32 && !ldpend_a_r && !rtc_enter |=> cnt32_r == $past(load32))
    else $error("32-bit counter did not reload after zero");
  a_stall_freeze: assert property (
    ce_in && is32 && halt_a && !ldpend_a_r && !rtc_enter |=> $stable(cnt32_r))
    else $error("counter moved while stalled");
  a_wide_halves_idle: assert property (
    wide |-> !run_a && !run_b)
    else $error("half running in 32-bit configuration");
  a_adc_chain_or: assert property (
    ce_in && adc_chain_in |=> adc_trig_out)
    else $error("chained ADC trigger lost");
  a_gpio_passthru: assert property (
    ce_in && !alternate_function_bit_a_in |=> ccp_a_out == $past(gpio_a_out_in)
      && ccp_a_oe_out == $past(gpio_a_oe_in))
    else $error("pin not under GPIO control");
  a_rtc_rollover: assert property (
    ce_in && rtc_hit && !rtc_enter |=> cnt32_r == 32'h0000_0000 ##0 ris_r[`DHT_ST_RTC])
    else $error("RTC did not roll over on match");
endmodule

// *** testbench/dht_pin_model.sv ***
/*
  Model of the outside world at the two timer pins.
  Assumes the bench starts the slow clock and pulses the odd pin on request.
*/
`timescale 1ns/1ps
module dht_pin_model (
  input wire logic clk_in,
  input wire logic rtc_run_in,
  input wire logic b_drive_in,
  input wire logic a_out_in,
  input wire logic a_oe_in,
  input wire logic b_out_in,
  input wire logic b_oe_in,
  output logic a_pin_out,
  output logic b_pin_out
);
  logic wave_r;
  logic [1:0] div_r;
  initial begin
    wave_r = 1'b0;
    div_r = 2'h0;
  end
  // Scaled slow clock, still when not running
  always @(posedge clk_in) begin
    if (!rtc_run_in) begin
      wave_r <= 1'b0;
      div_r <= 2'h0;
    end else if (div_r == 2'h2) begin
      div_r <= 2'h0;
      wave_r <= ~wave_r;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end
  // Undriven pins show the slow clock or the bench pulse
  assign a_pin_out = a_oe_in ? a_out_in : wave_r;
  assign b_pin_out = b_oe_in ? b_out_in : b_drive_in;
endmodule

// *** testbench/dht_timer_tb_top.sv ***
/*
  Self-checking bench of the dual half timer, register tasks and scenarios.
  Assumes the design files under logic/ and the pin model are compiled first.
*/
`timescale 1ns/1ps
`include "dht_defines.svh"
module dht_timer_tb_top;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic halt = 1'b0;
  logic alternate_function_bit_a = 1'b0;
  logic alternate_function_bit_b = 1'b0;
  logic gpio_a_out = 1'b0;
  logic gpio_b_out = 1'b0;
  logic gpio_b_oe = 1'b0;
  logic chain = 1'b0;
  logic rtc_run = 1'b0;
  logic b_drive = 1'b0;
  logic [31:0] rdata_out;
  logic a_out, a_oe, b_out, b_oe, a_pin, b_pin, adc_trig_out;
  int n_errors = 0;
  int n_tests = 0;
  logic [31:0] v, v2;
  int n;
  always #12.5 clk_in = ~clk_in;

  dht_timer #(.RTC_DIV(4)) dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(1'b1),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata_out),
    .halt_in(halt), .alternate_function_bit_a_in(alternate_function_bit_a), .alternate_function_bit_b_in(alternate_function_bit_b), .gpio_a_out_in(gpio_a_out),
    .gpio_a_oe_in(1'b0), .gpio_b_out_in(gpio_b_out), .gpio_b_oe_in(gpio_b_oe),
    .ccp_a_in(a_pin), .ccp_b_in(b_pin), .ccp_a_out(a_out), .ccp_a_oe_out(a_oe),
    .ccp_b_out(b_out), .ccp_b_oe_out(b_oe), .adc_chain_in(chain),
    .adc_trig_out(adc_trig_out));
  dht_pin_model model_u (.clk_in(clk_in), .rtc_run_in(rtc_run), .b_drive_in(b_drive),
    .a_out_in(a_out), .a_oe_in(a_oe), .b_out_in(b_out), .b_oe_in(b_oe),
    .a_pin_out(a_pin), .b_pin_out(b_pin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  // Read data only stands in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    d = rdata_out;
    @(posedge clk_in);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rreg(a, d);
    check(d & m, e, "register read");
  endtask
  // Cycles between two trigger pulses, bounded
  task automatic gap(output int g);
    int k;
    k = 0;
    g = 0;
    @(negedge clk_in);
    while (adc_trig_out !== 1'b1 && k < 300) begin
      @(negedge clk_in);
      k++;
    end
    do begin
      @(negedge clk_in);
      g++;
    end while (adc_trig_out !== 1'b1 && g < 300);
  endtask
  task automatic duty(output int h);
    h = 0;
    repeat (10) begin
      @(negedge clk_in);
      if (b_out === 1'b1) h++;
    end
  endtask
  // Odd pin edges held three cycles, above the one-cycle minimum
  task automatic pulse_b(input int k);
    repeat (k) begin
      @(posedge clk_in);
      b_drive <= 1'b1;
      cyc(3);
      b_drive <= 1'b0;
      cyc(3);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_in);
    n_errors++;
    complete_run;
  end

  initial begin
    cyc(12);
    arst_n_in <= 1'b1;
    rchk(`DHT_OFF_CFG, 32'hffffffff, 32'h0);
    rchk(`DHT_OFF_AMODE, 32'hffffffff, 32'h0);
    rchk(`DHT_OFF_BMODE, 32'hffffffff, 32'h0);
    rchk(`DHT_OFF_CTL, 32'hffffffff, 32'h0);
    rchk(`DHT_OFF_ALOAD, 32'hffffffff, 32'hffffffff);
    rchk(`DHT_OFF_AVAL, 32'hffffffff, 32'hffffffff);
    rchk(`DHT_OFF_APRE, 32'hffffffff, 32'h0);
    rchk(`DHT_OFF_BPRE, 32'hffffffff, 32'h0);
    rchk(`DHT_OFF_RIS, 32'hffffffff, 32'h0);
    rchk(8'h40, 32'hffffffff, 32'h0);
    gpio_a_out <= 1'b1;
    gpio_b_out <= 1'b1;
    gpio_b_oe <= 1'b1;
    cyc(3);
    check({b_out, b_oe, a_out, a_oe}, 32'he, "port drive");
    $display("test reset done");
    wreg(`DHT_OFF_CFG, 32'h2);
    rchk(`DHT_OFF_CFG, 32'h7, 32'h0);
    wreg(`DHT_OFF_CFG, 32'h4);
    rchk(`DHT_OFF_CFG, 32'h7, 32'h4);
    rchk(`DHT_OFF_AVAL, 32'hffffffff, 32'hffff);
    rchk(`DHT_OFF_BVAL, 32'hffffffff, 32'hffff);
    wreg(`DHT_OFF_CFG, 32'h0);
    rchk(`DHT_OFF_CFG, 32'h7, 32'h0);
    wreg(`DHT_OFF_AMODE, 32'h1);
    wreg(`DHT_OFF_ALOAD, 32'h2);
    wreg(`DHT_OFF_CTL, 32'h09);
    gap(n);
    check(n, 3, "32-bit period");
    wreg(`DHT_OFF_CTL, 32'h0);
    rchk(`DHT_OFF_MIS, 32'h1, 32'h0);
    wreg(`DHT_OFF_IMR, 32'h1);
    rchk(`DHT_OFF_MIS, 32'h1, 32'h1);
    wreg(`DHT_OFF_ICR, 32'h3f);
    rchk(`DHT_OFF_RIS, 32'h1, 32'h0);
    $display("test periodic done");
    wreg(`DHT_OFF_AMODE, 32'h0);
    wreg(`DHT_OFF_ALOAD, 32'h1000);
    halt <= 1'b1;
    wreg(`DHT_OFF_CTL, 32'h03);
    cyc(4);
    rreg(`DHT_OFF_AVAL, v);
    cyc(10);
    rreg(`DHT_OFF_AVAL, v2);
    check(v2, v, "frozen count");
    halt <= 1'b0;
    cyc(5);
    rreg(`DHT_OFF_AVAL, v);
    check(v < v2, 32'h1, "count resumed");
    wreg(`DHT_OFF_ALOAD, 32'h5);
    cyc(20);
    rchk(`DHT_OFF_CTL, 32'h1, 32'h0);
    rchk(`DHT_OFF_RIS, 32'h1, 32'h1);
    $display("test one-shot done");
    wreg(`DHT_OFF_CFG, 32'h4);
    wreg(`DHT_OFF_AMODE, 32'h1);
    wreg(`DHT_OFF_ALOAD, 32'h3);
    wreg(`DHT_OFF_APRE, 32'h1);
    wreg(`DHT_OFF_BMODE, 32'h4);
    wreg(`DHT_OFF_BLOAD, 32'h9);
    wreg(`DHT_OFF_BMATCH, 32'h3);
    alternate_function_bit_b <= 1'b1;
    wreg(`DHT_OFF_CTL, 32'h0109);
    gap(n);
    check(n, 8, "prescaled period");
    cyc(20);
    check({b_oe, a_oe}, 32'h2, "pin enables");
    duty(n);
    check(n, 6, "pwm high");
    wreg(`DHT_OFF_CTL, 32'h1109);
    cyc(20);
    duty(n);
    check(n, 4, "pwm inverted");
    $display("test split halves done");
    wreg(`DHT_OFF_CTL, 32'h0);
    wreg(`DHT_OFF_BMODE, 32'h2);
    wreg(`DHT_OFF_BLOAD, 32'ha);
    wreg(`DHT_OFF_BMATCH, 32'h7);
    wreg(`DHT_OFF_ICR, 32'h3f);
    wreg(`DHT_OFF_CTL, 32'h0100);
    pulse_b(1);
    rchk(`DHT_OFF_RIS, 32'h20, 32'h0);
    pulse_b(4);
    rchk(`DHT_OFF_RIS, 32'h20, 32'h20);
    $display("test edge count done");
    wreg(`DHT_OFF_CTL, 32'h0);
    wreg(`DHT_OFF_BMODE, 32'h3);
    wreg(`DHT_OFF_ICR, 32'h3f);
    wreg(`DHT_OFF_CTL, 32'h0500);
    @(posedge clk_in);
    b_drive <= 1'b1;
    cyc(4);
    rchk(`DHT_OFF_RIS, 32'h20, 32'h0);
    b_drive <= 1'b0;
    cyc(4);
    rchk(`DHT_OFF_RIS, 32'h20, 32'h20);
    rreg(`DHT_OFF_BVAL, v);
    cyc(7);
    rreg(`DHT_OFF_BVAL, v2);
    check(v2, v, "captured time held");
    check(v <= 32'ha, 32'h1, "captured time range");
    $display("test edge time done");
    wreg(`DHT_OFF_CTL, 32'h0);
    alternate_function_bit_a <= 1'b1;
    wreg(`DHT_OFF_CFG, 32'h1);
    rchk(`DHT_OFF_AVAL, 32'hffffffff, 32'h1);
    wreg(`DHT_OFF_AMATCH, 32'h3);
    wreg(`DHT_OFF_ICR, 32'h3f);
    wreg(`DHT_OFF_CTL, 32'h01);
    cyc(30);
    rchk(`DHT_OFF_RIS, 32'h4, 32'h0);
    rtc_run <= 1'b1;
    cyc(100);
    rchk(`DHT_OFF_RIS, 32'h4, 32'h4);
    rtc_run <= 1'b0;
    $display("test clock done");
    @(posedge clk_in);
    chain <= 1'b1;
    @(posedge clk_in);
    chain <= 1'b0;
    #1 check(adc_trig_out, 32'h1, "trigger chain");
    $display("test chain done");
    complete_run;
  end
endmodule
